// File: rtl/bsc_pkg.sv
// Purpose: Shared constants, operation codes and state types for the bit, skip,
//          call and clear execution block.
// Assumes: The decoder ahead of this block maps each instruction onto one bsc_op_t code.
// Notes:   Every width, reset value and cycle count used by more than one file lives here.
package bsc_pkg;

    // ------------------------------------------------------------------
    // Widths of the data path
    // ------------------------------------------------------------------
    localparam int unsigned BSC_DATA_W  = 8;   // File register and accumulator width.
    localparam int unsigned BSC_ADDR_W  = 6;   // File register address, 0 to 63.
    localparam int unsigned BSC_BIT_W   = 3;   // Bit position, 0 to 7.
    localparam int unsigned BSC_IMM_W   = 10;  // Call immediate, program counter bits 9 to 0.
    localparam int unsigned BSC_PAGE_W  = 2;   // Page select bits, program counter bits 11 and 10.
    localparam int unsigned BSC_PC_W    = BSC_IMM_W + BSC_PAGE_W;

    // ------------------------------------------------------------------
    // Fixed values
    // ------------------------------------------------------------------
    localparam logic [BSC_DATA_W-1:0] BSC_ZERO_BYTE  = 8'h00;  // Value written by the clears.
    localparam logic [BSC_PC_W-1:0]   BSC_PC_STEP    = 12'h001; // Return address offset.
    localparam logic [3:0]            BSC_NIB_LIMIT  = 4'h9;   // Largest decimal digit.
    localparam logic [BSC_DATA_W:0]   BSC_LO_FIX     = 9'h006; // Low digit correction.
    localparam logic [BSC_DATA_W:0]   BSC_HI_FIX     = 9'h060; // High digit correction.

    // ------------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------------
    localparam int unsigned BSC_CYC_SINGLE = 1;  // Plain instructions and untaken skips.
    localparam int unsigned BSC_CYC_DOUBLE = 2;  // Call and taken skips.

    // ------------------------------------------------------------------
    // Operation codes handed over by the decoder
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        BSC_OP_NONE       = 4'h0,
        BSC_OP_BIT_CLEAR  = 4'h1,  // bit_clear_op
        BSC_OP_BIT_SET    = 4'h2,  // bit_set_op
        BSC_OP_SKIP_ZERO  = 4'h3,  // test_skip_if_zero_op
        BSC_OP_SKIP_ONE   = 4'h4,  // test_skip_if_one_op
        BSC_OP_CALL       = 4'h5,  // Subroutine call.
        BSC_OP_CLR_ACCUM  = 4'h6,  // clear_accum_op
        BSC_OP_CLR_FILE   = 4'h7,  // clear_file_reg_op
        BSC_OP_WDT_CLEAR  = 4'h8,  // watchdog_clear_op
        BSC_OP_COMPLEMENT = 4'h9,  // complement_op
        BSC_OP_DEC_ADJUST = 4'hA   // decimal_adjust_add_op
    } bsc_op_t;

    // ------------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BSC_ST_EXEC = 3'b001,  // Ready to take an instruction.
        BSC_ST_CALL = 3'b010,  // Second cycle of a call.
        BSC_ST_NOP  = 3'b100   // Substituted no-operation of a taken skip.
    } bsc_state_t;

    // ------------------------------------------------------------------
    // Complete registered state of the execution block
    // ------------------------------------------------------------------
    typedef struct packed {
        bsc_state_t            st;
        logic                  rf_we;
        logic [BSC_ADDR_W-1:0] rf_addr;
        logic [BSC_DATA_W-1:0] rf_wdata;
        logic                  acc_we;
        logic [BSC_DATA_W-1:0] acc_wdata;
        logic                  z_we;
        logic                  z_val;
        logic                  c_we;
        logic                  c_val;
        logic                  stk_push;
        logic [BSC_PC_W-1:0]   stk_data;
        logic                  pc_load;
        logic [BSC_PC_W-1:0]   pc_target;
        logic                  flush;
        logic                  pc_adv;
        logic                  wdt_clr;
        logic                  presc_clr;
        logic                  flags_set;
    } bsc_regs_t;

    localparam bsc_regs_t BSC_REGS_RST = '{
        st:        BSC_ST_EXEC,
        rf_addr:   '0,
        rf_wdata:  '0,
        acc_wdata: '0,
        stk_data:  '0,
        pc_target: '0,
        default:   1'b0
    };

endpackage : bsc_pkg

// File: rtl/bsc_dec_adjust.sv
// Purpose: Packed decimal correction of the accumulator after an addition.
// Assumes: Carry and digit carry are those left by the preceding addition.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module bsc_dec_adjust
    import bsc_pkg::*;
(
    input  wire logic [BSC_DATA_W-1:0] i_acc,     // Binary sum to correct.
    input  wire logic                  i_carry,   // Carry from the addition.
    input  wire logic                  i_dcarry,  // Digit carry from the addition.
    output logic      [BSC_DATA_W-1:0] o_result,  // Packed decimal value.
    output logic                       o_carry    // Decimal carry out.
);

    logic              lo_fix;
    logic              hi_fix;
    logic [BSC_DATA_W:0] step1;
    logic [BSC_DATA_W:0] step2;

    // ------------------------------------------------------------------
    // Two-step correction
    // ------------------------------------------------------------------
    // The low digit is fixed first because its +6 can push the high digit over nine.
    always_comb begin
        lo_fix   = i_dcarry | (i_acc[3:0] > BSC_NIB_LIMIT);
        step1    = {1'b0, i_acc} + (lo_fix ? BSC_LO_FIX : '0);
        hi_fix   = i_carry | step1[BSC_DATA_W] | (step1[7:4] > BSC_NIB_LIMIT);
        step2    = step1 + (hi_fix ? BSC_HI_FIX : '0);
        o_result = step2[BSC_DATA_W-1:0];
        o_carry  = hi_fix;  // A carried high digit means the decimal sum passed 99.
    end

endmodule : bsc_dec_adjust

// File: rtl/bsc_exec.sv
// Purpose: Execution logic for bit clear and set, bit test and skip, subroutine call,
//          accumulator and register clear, watchdog clear, complement and decimal adjust.
// Assumes: The register file presents the addressed register on i_rd_data in the same
//          cycle as i_valid; the core stalls fetch while o_ready is low.
// Notes:   All effects are one-cycle strobes registered one edge after the instruction
//          is taken, or two edges after for o_pc_advance of a taken skip, so the core sees clean flop outputs at its write ports.
//
// Behaviour
// - Bit clear zeroes chosen bit, flags untouched.
// - Bit set forces chosen bit, flags untouched.
// - Skip-if-zero discards next instruction when bit clear.
// - Skip-if-one discards next instruction when bit set.
// - Call pushes return address, takes two cycles.
// - Call target is page bits plus immediate.
// - Accumulator clear writes zero, sets zero flag.
// - Register clear writes zero, sets zero flag.
// - Watchdog clear resets counter and assigned prescaler.
// - Watchdog clear sets timeout and powerdown flags.
// - Complement inverts register, destination selectable, zero flag.
// - Decimal adjust corrects accumulator, changes only carry.
// - Page select bits supply upper program counter.
`timescale 1ns/1ps
module bsc_exec
    import bsc_pkg::*;
#(
    parameter int unsigned P_DATA_W = BSC_DATA_W,  // File register width.
    parameter int unsigned P_ADDR_W = BSC_ADDR_W,  // File register address width.
    parameter int unsigned P_IMM_W  = BSC_IMM_W    // Call immediate width.
) (
    input  wire logic                  i_clk,         // Core instruction clock.
    input  wire logic                  i_rst_n,       // Asynchronous reset, active low.

    // Instruction from the decoder.
    input  wire logic                  i_valid,       // Instruction present.
    input  wire bsc_op_t               i_op,          // Decoded operation.
    input  wire logic [BSC_ADDR_W-1:0] i_reg_addr,    // File register address.
    input  wire logic [BSC_BIT_W-1:0]  i_bit_pos,     // Bit position.
    input  wire logic                  i_dest_file,   // Destination select, 1 = register.
    input  wire logic [BSC_IMM_W-1:0]  i_imm,         // Call immediate.
    output logic                       o_ready,       // Instruction can be taken.

    // Core state read by the block.
    input  wire logic [BSC_DATA_W-1:0] i_rd_data,     // Addressed register contents.
    input  wire logic [BSC_DATA_W-1:0] i_accumulator, // Current accumulator.
    input  wire logic                  i_carry,       // Current carry flag.
    input  wire logic                  i_dcarry,      // Current digit carry flag.
    input  wire logic [BSC_PC_W-1:0]   i_program_counter, // Address of this instruction.
    input  wire logic [BSC_PAGE_W-1:0] i_page_select_bits, // Program page select.
    input  wire logic                  i_presc_to_wdt, // Prescaler assigned to watchdog.

    // Register file write port.
    output logic                       o_rf_we,       // Register write strobe.
    output logic      [BSC_ADDR_W-1:0] o_rf_addr,     // Register write address.
    output logic      [BSC_DATA_W-1:0] o_rf_wdata,    // Register write data.

    // Accumulator and flags.
    output logic                       o_acc_we,      // Accumulator write strobe.
    output logic      [BSC_DATA_W-1:0] o_acc_wdata,   // Accumulator write data.
    output logic                       o_zero_we,     // Zero flag write strobe.
    output logic                       o_zero_flag,   // Zero flag value.
    output logic                       o_carry_we,    // Carry flag write strobe.
    output logic                       o_carry_flag,  // Carry flag value.

    // Stack and program counter.
    output logic                       o_stk_push,    // Push strobe.
    output logic      [BSC_PC_W-1:0]   o_stk_data,    // Return address to push.
    output logic                       o_pc_load,     // Load program counter.
    output logic      [BSC_PC_W-1:0]   o_pc_target,   // New program counter.
    output logic                       o_flush,       // Discard prefetched instruction.
    output logic                       o_pc_advance,  // No-operation cycle, advance only.

    // Watchdog.
    output logic                       o_wdt_clear,   // Clear watchdog_counter.
    output logic                       o_presc_clear, // Clear shared prescaler.
    output logic                       o_timeout_flag_set,   // Set timeout_flag.
    output logic                       o_powerdown_flag_set  // Set powerdown_flag.
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The state struct is built from the package widths, so other widths cannot be served.
    if (P_DATA_W != BSC_DATA_W || P_ADDR_W != BSC_ADDR_W || P_IMM_W != BSC_IMM_W) begin : g_chk
        $error("bsc_exec: widths must match the package widths");
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // One-hot mask for a bit position.
    function automatic logic [BSC_DATA_W-1:0] bit_mask(input logic [BSC_BIT_W-1:0] pos);
        logic [BSC_DATA_W-1:0] m;
        m      = '0;
        m[pos] = 1'b1;
        return m;
    endfunction : bit_mask

    // Zero test used for the zero flag.
    function automatic logic is_zero(input logic [BSC_DATA_W-1:0] v);
        return (v == BSC_ZERO_BYTE);
    endfunction : is_zero

    // Skip decision shared by both test codes.
    function automatic logic skip_hit(input logic on_one, input logic bit_val);
        return (bit_val == on_one);
    endfunction : skip_hit

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    bsc_regs_t             r_q;
    bsc_regs_t             r_d;
    logic                  take;
    logic                  tested_bit;
    logic [BSC_DATA_W-1:0] comp_val;
    logic [BSC_DATA_W-1:0] daa_val;
    logic                  daa_carry;

    // ------------------------------------------------------------------
    // Decimal correction datapath
    // ------------------------------------------------------------------
    bsc_dec_adjust u_dec_adjust (
        .i_acc    (i_accumulator),
        .i_carry  (i_carry),
        .i_dcarry (i_dcarry),
        .o_result (daa_val),
        .o_carry  (daa_carry)
    );

    // Instructions are only taken while no second cycle is pending.
    assign o_ready    = (r_q.st == BSC_ST_EXEC);
    assign take       = i_valid & o_ready;
    assign tested_bit = i_rd_data[i_bit_pos];
    assign comp_val   = ~i_rd_data;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Strobes default to low so every effect lasts exactly one cycle.
    always_comb begin
        r_d           = r_q;
        r_d.rf_we     = 1'b0;
        r_d.acc_we    = 1'b0;
        r_d.z_we      = 1'b0;
        r_d.c_we      = 1'b0;
        r_d.stk_push  = 1'b0;
        r_d.pc_load   = 1'b0;
        r_d.flush     = 1'b0;
        r_d.pc_adv    = 1'b0;
        r_d.wdt_clr   = 1'b0;
        r_d.presc_clr = 1'b0;
        r_d.flags_set = 1'b0;

        // Only the ready state takes an instruction.
        unique case (r_q.st)
            BSC_ST_EXEC: begin
                if (take) begin
                    unique case (i_op)
                        BSC_OP_BIT_CLEAR: begin
                            r_d.rf_we    = 1'b1;
                            r_d.rf_addr  = i_reg_addr;
                            r_d.rf_wdata = i_rd_data & ~bit_mask(i_bit_pos);
                        end

                        BSC_OP_BIT_SET: begin
                            r_d.rf_we    = 1'b1;
                            r_d.rf_addr  = i_reg_addr;
                            r_d.rf_wdata = i_rd_data | bit_mask(i_bit_pos);
                        end

                        BSC_OP_SKIP_ZERO: begin
                            if (skip_hit(1'b0, tested_bit)) begin
                                r_d.flush = 1'b1;
                                r_d.st    = BSC_ST_NOP;
                            end
                        end

                        BSC_OP_SKIP_ONE: begin
                            if (skip_hit(1'b1, tested_bit)) begin
                                r_d.flush = 1'b1;
                                r_d.st    = BSC_ST_NOP;
                            end
                        end

                        BSC_OP_CALL: begin
                            r_d.stk_push  = 1'b1;
                            r_d.stk_data  = i_program_counter + BSC_PC_STEP;
                            r_d.pc_load   = 1'b1;
                            r_d.flush     = 1'b1;
                            // Upper bits come from the page select, not the old counter.
                            r_d.pc_target = {i_page_select_bits, i_imm};
                            r_d.st        = BSC_ST_CALL;
                        end

                        BSC_OP_CLR_ACCUM: begin
                            r_d.acc_we    = 1'b1;
                            r_d.acc_wdata = BSC_ZERO_BYTE;
                            r_d.z_we      = 1'b1;
                            r_d.z_val     = 1'b1;
                        end

                        BSC_OP_CLR_FILE: begin
                            r_d.rf_we    = 1'b1;
                            r_d.rf_addr  = i_reg_addr;
                            r_d.rf_wdata = BSC_ZERO_BYTE;
                            r_d.z_we     = 1'b1;
                            r_d.z_val    = 1'b1;
                        end

                        BSC_OP_WDT_CLEAR: begin
                            r_d.wdt_clr   = 1'b1;
                            // Timer0 keeps its prescaler when it owns it.
                            r_d.presc_clr = i_presc_to_wdt;
                            r_d.flags_set = 1'b1;
                        end

                        BSC_OP_COMPLEMENT: begin
                            r_d.z_we  = 1'b1;
                            r_d.z_val = is_zero(comp_val);
                            if (i_dest_file) begin
                                r_d.rf_we    = 1'b1;
                                r_d.rf_addr  = i_reg_addr;
                                r_d.rf_wdata = comp_val;
                            end else begin
                                r_d.acc_we    = 1'b1;
                                r_d.acc_wdata = comp_val;
                            end
                        end

                        BSC_OP_DEC_ADJUST: begin
                            r_d.acc_we    = 1'b1;
                            r_d.acc_wdata = daa_val;
                            r_d.c_we      = 1'b1;
                            r_d.c_val     = daa_carry;
                        end

                        default: begin
                            // Codes outside this group belong to other units.
                        end
                    endcase
                end
            end

            BSC_ST_CALL: begin
                // Target fetch cycle; nothing else moves.
                r_d.st = BSC_ST_EXEC;
            end

            BSC_ST_NOP: begin
                // All write strobes stay low, only the counter steps on.
                r_d.pc_adv = 1'b1;
                r_d.st     = BSC_ST_EXEC;
            end

            default: begin
                // An illegal one-hot code returns to the ready state.
                r_d.st = BSC_ST_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r_q <= BSC_REGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign o_rf_we              = r_q.rf_we;
    assign o_rf_addr            = r_q.rf_addr;
    assign o_rf_wdata           = r_q.rf_wdata;

    // Accumulator and flag writes; only strobed flags move in the core.
    assign o_acc_we             = r_q.acc_we;
    assign o_acc_wdata          = r_q.acc_wdata;
    assign o_zero_we            = r_q.z_we;
    assign o_zero_flag          = r_q.z_val;
    assign o_carry_we           = r_q.c_we;
    assign o_carry_flag         = r_q.c_val;

    // Stack push and program counter redirect.
    assign o_stk_push           = r_q.stk_push;
    assign o_stk_data           = r_q.stk_data;
    assign o_pc_load            = r_q.pc_load;
    assign o_pc_target          = r_q.pc_target;
    assign o_flush              = r_q.flush;
    assign o_pc_advance         = r_q.pc_adv;

    // Watchdog strobes.
    assign o_wdt_clear          = r_q.wdt_clr;
    assign o_presc_clear        = r_q.presc_clr;
    assign o_timeout_flag_set   = r_q.flags_set;   // Both status flags set together.
    assign o_powerdown_flag_set = r_q.flags_set;

endmodule : bsc_exec

// File: verif/bsc_exec_props.sv
// Purpose: Port-level concurrent checks of the execution block.
// Assumes: One clock; every effect follows the taken edge by one cycle, o_pc_advance of a taken skip by two.
// Notes:   Skip and call checks also span the refused gap cycle.
`timescale 1ns/1ps
module bsc_exec_props
    import bsc_pkg::*;
(
    input wire logic                  i_clk, i_rst_n, i_valid, i_dest_file, // Control.
    input wire bsc_op_t               i_op,                                  // Operation.
    input wire logic [BSC_BIT_W-1:0]  i_bit_pos,                             // Bit.
    input wire logic [BSC_DATA_W-1:0] i_rd_data, o_rf_wdata, o_acc_wdata,    // Data.
    input wire logic [BSC_IMM_W-1:0]  i_imm,                                 // Immediate.
    input wire logic [BSC_PC_W-1:0]   i_program_counter, o_stk_data, o_pc_target, // PC.
    input wire logic [BSC_PAGE_W-1:0] i_page_select_bits,                    // Page.
    input wire logic                  i_presc_to_wdt, o_ready, o_rf_we, o_acc_we, // Effects.
    input wire logic                  o_zero_we, o_zero_flag, o_carry_we, o_stk_push,
    input wire logic                  o_pc_load, o_flush, o_pc_advance, o_wdt_clear,
    input wire logic                  o_presc_clear, o_timeout_flag_set, o_powerdown_flag_set
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [3:0] tk;
    logic [7:0] msk;
    // Operation really taken at this edge; a refused request reads as none.
    assign tk  = (i_valid && o_ready) ? i_op : 4'h0;
    assign msk = 8'h01 << i_bit_pos;
    property p_bclr; tk == BSC_OP_BIT_CLEAR |=> o_rf_we && !o_zero_we && !o_carry_we
        && o_rf_wdata == ($past(i_rd_data) & ~$past(msk)); endproperty
    a_bclr: assert property (p_bclr) else $error("bit clear wrong");
    property p_skip; (tk == BSC_OP_SKIP_ZERO && !i_rd_data[i_bit_pos])
        || (tk == BSC_OP_SKIP_ONE && i_rd_data[i_bit_pos]) |=> o_flush && !o_ready
        ##1 o_pc_advance && o_ready && !o_rf_we && !o_acc_we && !o_stk_push; endproperty
    a_skip: assert property (p_skip) else $error("taken skip wrong");
    property p_call; tk == BSC_OP_CALL |=> o_stk_push && o_pc_load && !o_ready
        && o_stk_data == $past(i_program_counter) + BSC_PC_STEP
        && o_pc_target == {$past(i_page_select_bits), $past(i_imm)} ##1 o_ready; endproperty
    a_call: assert property (p_call) else $error("call wrong");
    property p_cacc; tk == BSC_OP_CLR_ACCUM |=> o_acc_we && o_acc_wdata == BSC_ZERO_BYTE
        && o_zero_we && o_zero_flag && !o_rf_we; endproperty
    a_cacc: assert property (p_cacc) else $error("accumulator clear wrong");
    property p_cfile; tk == BSC_OP_CLR_FILE |=> o_rf_we && o_rf_wdata == BSC_ZERO_BYTE
        && o_zero_we && o_zero_flag && !o_acc_we; endproperty
    a_cfile: assert property (p_cfile) else $error("register clear wrong");
    property p_wdt; tk == BSC_OP_WDT_CLEAR |=> o_wdt_clear && o_timeout_flag_set
        && o_powerdown_flag_set && o_presc_clear == $past(i_presc_to_wdt); endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
    property p_comp; tk == BSC_OP_COMPLEMENT |=> o_zero_we && o_rf_we == $past(i_dest_file)
        && o_acc_we == !$past(i_dest_file) && o_zero_flag == ($past(i_rd_data) == 8'hFF);
    endproperty
    a_comp: assert property (p_comp) else $error("complement wrong");
    property p_daa; tk == BSC_OP_DEC_ADJUST |=> o_acc_we && o_carry_we && !o_zero_we
        && !o_rf_we; endproperty
    a_daa: assert property (p_daa) else $error("decimal adjust wrong");
    c_call: cover property (tk == BSC_OP_CALL);
    c_skip: cover property (o_pc_advance);
    c_comp: cover property (tk == BSC_OP_COMPLEMENT && i_dest_file);
endmodule : bsc_exec_props
bind bsc_exec bsc_exec_props i_props (.*);

// File: verif/tb_bit_skip_call_clear_exec.sv
// Purpose: Random self-checking bench for the execution block.
// Assumes: Inputs change on the falling edge; effects are read one cycle later.
// Notes:   Expectations come from bench functions, never from the block's outputs.
`timescale 1ns/1ps
module tb_bit_skip_call_clear_exec
    import bsc_pkg::*;
;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_valid = 1'b0, i_dest_file, i_carry, i_dcarry;
    logic i_presc_to_wdt, o_ready, o_rf_we, o_acc_we, o_zero_we, o_zero_flag, o_carry_we;
    logic o_carry_flag, o_stk_push, o_pc_load, o_flush, o_pc_advance, o_wdt_clear;
    logic o_presc_clear, o_timeout_flag_set, o_powerdown_flag_set;
    bsc_op_t i_op = BSC_OP_NONE;
    logic [5:0] i_reg_addr, o_rf_addr;
    logic [2:0] i_bit_pos;
    logic [9:0] i_imm;
    logic [7:0] i_rd_data, i_accumulator, o_rf_wdata, o_acc_wdata;
    logic [11:0] i_program_counter, o_stk_data, o_pc_target;
    logic [1:0] i_page_select_bits;
    int fail_count = 0;
    int check_count = 0;
    always #12.5 i_clk = ~i_clk;
    bsc_exec i_dut (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    // Packed decimal correction; the carry out is the high digit fix.
    function automatic logic [8:0] daa_exp(input logic [7:0] a, input logic c, input logic dc);
        logic [8:0] t;
        logic       hf;
        t  = {1'b0, a} + ((dc || a[3:0] > 4'h9) ? 9'h006 : 9'h000);
        hf = c || t[8] || t[7:4] > 4'h9;
        t  = t + (hf ? 9'h060 : 9'h000);
        return {hf, t[7:0]};
    endfunction : daa_exp
    // Presents one instruction, other operands random, and checks it one cycle later.
    task automatic run(input bsc_op_t op, input logic [7:0] rd, input logic [7:0] acc);
        logic       tk;
        logic [7:0] m;
        i_valid = 1'b1;
        i_op = op;
        i_rd_data = rd;
        i_accumulator = acc;
        {i_reg_addr, i_bit_pos, i_dest_file, i_imm} = 20'($urandom);
        {i_program_counter, i_page_select_bits, i_carry, i_dcarry, i_presc_to_wdt} = 17'($urandom);
        m = 8'h01 << i_bit_pos;
        tk = (op == BSC_OP_SKIP_ZERO && !rd[i_bit_pos])
            || (op == BSC_OP_SKIP_ONE && rd[i_bit_pos]);
        @(negedge i_clk);
        chk({o_stk_push, o_flush, o_ready}, {op == BSC_OP_CALL, op == BSC_OP_CALL || tk,
             !(op == BSC_OP_CALL || tk)});
        case (op)
            BSC_OP_BIT_CLEAR: chk({o_rf_we, o_zero_we, o_rf_wdata}, {2'b10, rd & ~m});
            BSC_OP_BIT_SET: chk({o_rf_we, o_carry_we, o_rf_wdata}, {2'b10, rd | m});
            BSC_OP_CALL: chk({o_pc_load, o_stk_data, o_pc_target}, {1'b1, i_program_counter
                + 12'h001, i_page_select_bits, i_imm});
            BSC_OP_CLR_ACCUM: chk({o_acc_we, o_zero_we, o_zero_flag, o_acc_wdata},
                11'h700);
            BSC_OP_CLR_FILE: chk({o_rf_we, o_zero_flag, o_rf_addr, o_rf_wdata},
                {2'b11, i_reg_addr, 8'h00});
            BSC_OP_WDT_CLEAR: chk({o_wdt_clear, o_presc_clear, o_timeout_flag_set,
                o_powerdown_flag_set}, {1'b1, i_presc_to_wdt, 2'b11});
            BSC_OP_COMPLEMENT: chk({o_rf_we, o_acc_we, o_zero_flag, i_dest_file ? o_rf_wdata
                : o_acc_wdata}, {i_dest_file, !i_dest_file, rd == 8'hFF, ~rd});
            BSC_OP_DEC_ADJUST: chk({o_acc_we, o_zero_we, o_carry_flag, o_acc_wdata},
                {2'b10, daa_exp(acc, i_carry, i_dcarry)});
            default: chk({o_rf_we, o_acc_we, o_zero_we, o_wdt_clear}, 4'h0);
        endcase
        if (op == BSC_OP_CALL || tk) begin
            i_op = BSC_OP_BIT_SET; // Offered while not ready, so it must be dropped.
            @(negedge i_clk);
            chk({o_ready, o_rf_we, o_stk_push, o_pc_advance}, {3'b100, tk});
        end
    endtask : run
    initial begin
        {i_reg_addr, i_bit_pos, i_dest_file, i_imm, i_carry, i_dcarry, i_presc_to_wdt} = '0;
        {i_rd_data, i_accumulator, i_program_counter, i_page_select_bits} = '0;
        void'($urandom(80));
        repeat (4) @(negedge i_clk);
        i_rst_n = 1'b1;
        // Back-to-back taken skips and calls, then untaken skips and awkward values.
        run(BSC_OP_SKIP_ZERO, 8'h00, 8'h00);
        run(BSC_OP_SKIP_ONE, 8'hFF, 8'h00);
        run(BSC_OP_CALL, 8'h00, 8'h00);
        run(BSC_OP_CALL, 8'h00, 8'h00);
        run(BSC_OP_SKIP_ZERO, 8'hFF, 8'h00);
        run(BSC_OP_SKIP_ONE, 8'h00, 8'h00);
        run(BSC_OP_COMPLEMENT, 8'hFF, 8'h00);
        run(BSC_OP_DEC_ADJUST, 8'h00, 8'h9A);
        run(BSC_OP_DEC_ADJUST, 8'h00, 8'h99);
        for (int k = 0; k < 300; k++) begin
            run(bsc_op_t'(4'($urandom_range(10, 0))), 8'($urandom), 8'($urandom));
        end
        i_valid = 1'b0;
        repeat (2) @(negedge i_clk);
        test_done();
    end
endmodule : tb_bit_skip_call_clear_exec
